// ===== hdl/ecd_defs.vh
// Shared constants for the embedded clock deserializer
`ifndef ECD_DEFS_VH
`define ECD_DEFS_VH
// =====================================================
// Frame layout
`define ECD_FRAME_BITS   12
`define ECD_DATA_BITS    10
`define ECD_PH_LAST      4'hb
`define ECD_HALF_FRAME   4'h6
`define ECD_START_POS    11
`define ECD_STOP_POS     0
// =====================================================
// Acquisition counts
`define ECD_ACQ_FRAMES   8
`define ECD_REF_EDGES    16
// =====================================================
// Reset values
`define ECD_LOCK_N_RST   1'b1
`define ECD_WORD_RST     10'h000
`endif

// ===== hdl/ecd_word_buffer.v
// Two-entry word buffer with valid and ready on both sides
`timescale 1ns/10ps
module ecd_word_buffer #(
  parameter WIDTH = 10
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rstN,
  // Flush, empties the buffer
  input  wire             flush,
  // Fill side
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  // Drain side
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);
  // =====================================================
  // Storage
  reg [WIDTH-1:0] ent0_r;
  reg [WIDTH-1:0] ent1_r;
  reg [1:0]       cnt_r;
  wire            doPush;
  wire            doPop;

  // Handshakes
  assign inReady  = (cnt_r != 2'h2);
  assign outValid = (cnt_r != 2'h0);
  assign outData  = ent0_r;
  assign doPush   = inValid & inReady;
  assign doPop    = outValid & outReady;

  // Head entry is ent0, second is ent1
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ent0_r <= {WIDTH{1'b0}};
      ent1_r <= {WIDTH{1'b0}};
      cnt_r  <= 2'h0;
    end else if (flush) begin
      cnt_r <= 2'h0;
    end else begin
      case ({doPush, doPop})
        2'b10: begin
          if (cnt_r == 2'h0) ent0_r <= inData;
          else ent1_r <= inData;
          cnt_r <= cnt_r + 2'h1;
        end
        2'b01: begin
          ent0_r <= ent1_r;
          cnt_r  <= cnt_r - 2'h1;
        end
        2'b11: begin
          if (cnt_r == 2'h1) ent0_r <= inData;
          else begin
            ent0_r <= ent1_r;
            ent1_r <= inData;
          end
        end
        default: begin
          cnt_r <= cnt_r;
        end
      endcase
    end
  end
endmodule

// ===== hdl/ecd_deserializer.v
// Embedded clock deserializer: frame alignment, lock, word output
//
// Summary of operation
// - Outputs float and logic stays idle until reset release.
// - Lock indicator stays high while acquiring.
// - Lock on random data; bounded lock time on training pattern.
// - Transitions on serial input start the alignment search.
// - Lock indicator low once aligned; words valid only then.
// - Frame is start bit 1, ten data bits, stop bit 0.
// - Serial bit rate is twelve times the word rate.
// - Words are aligned to recovered clock; edge select picks edge.
// - Lost alignment raises lock indicator and floats outputs.
// - Each frame becomes one ten bit word per recovered period.
// - Output enable low floats words and clock; lock stays driven.
// - Power down with output enable low stops acquisition.
// - Several candidate clock positions keep lock indicator inactive.
`timescale 1ns/10ps
`include "ecd_defs.vh"
module ecd_deserializer #(
  parameter ACQ_FRAMES = `ECD_ACQ_FRAMES,
  parameter REF_EDGES  = `ECD_REF_EDGES
) (
  // Clock and reset
  input  wire       core_clk,
  input  wire       rst_b,
  // Link and reference inputs, asynchronous
  input  wire       serialIn,
  input  wire       localReferenceClock,
  // Control inputs, asynchronous
  input  wire       powerDownN,
  input  wire       rxOutputEnable,
  input  wire       rxEdgeSelect,
  // Status
  output wire       lockN,
  output wire       wordOverrun,
  // Parallel word output
  output wire [9:0] parallelWordOut,
  output wire       parallelWordOe,
  output wire       parallelWordValid,
  input  wire       parallelWordReady,
  // Recovered word clock
  output wire       recClkOut,
  output wire       recClkOe
);
  // =====================================================
  // States
  localparam [3:0] ST_OFF  = 4'h1;
  localparam [3:0] ST_IDLE = 4'h2;
  localparam [3:0] ST_ACQ  = 4'h4;
  localparam [3:0] ST_LOCK = 4'h8;

  // =====================================================
  // Reset and input synchronisers
  reg  [1:0]  rstSync_r;
  wire        rstN;
  reg  [4:0]  inMeta_r;
  reg  [4:0]  inSync_r;
  wire        serBit;
  wire        refLvl;
  wire        pwrN;
  wire        outEn;
  wire        edgeSel;

  // Reset leaves through two flops
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) rstSync_r <= 2'h0;
    else rstSync_r <= {rstSync_r[0], 1'b1};
  end
  assign rstN = rstSync_r[1];

  // Two flops on every asynchronous pin input
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      inMeta_r <= 5'h00;
      inSync_r <= 5'h00;
    end else begin
      inMeta_r <= {rxEdgeSelect, rxOutputEnable, powerDownN, localReferenceClock, serialIn};
      inSync_r <= inMeta_r;
    end
  end
  assign serBit  = inSync_r[0];
  assign refLvl  = inSync_r[1];
  assign pwrN    = inSync_r[2];
  assign outEn   = inSync_r[3];
  assign edgeSel = inSync_r[4];

  // =====================================================
  // Reference clock qualification
  reg        refPrev_r;
  reg [7:0]  refCnt_r;
  wire       refLocked;
  wire       stopped;

  // Stop only when both power and output enable are low
  assign stopped   = ~pwrN & ~outEn;
  assign refLocked = (refCnt_r == REF_EDGES[7:0]);

  // Count reference edges before looking at the stream
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      refPrev_r <= 1'b0;
      refCnt_r  <= 8'h00;
    end else begin
      refPrev_r <= refLvl;
      if (stopped) refCnt_r <= 8'h00;
      else if (refLvl & ~refPrev_r & ~refLocked) refCnt_r <= refCnt_r + 8'h01;
    end
  end

  // =====================================================
  // Bit shifter and phase counter
  reg  [11:0] sr_r;
  reg  [3:0]  ph_r;
  reg         prevBit_r;
  wire        patOk;
  wire        edgeSeen;

  // Start bit eleven bits back, stop bit now
  assign patOk    = sr_r[`ECD_START_POS] & ~sr_r[`ECD_STOP_POS];
  assign edgeSeen = serBit ^ prevBit_r;

  // One serial bit per clock, frame of twelve bits
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      sr_r      <= 12'h000;
      ph_r      <= 4'h0;
      prevBit_r <= 1'b0;
    end else begin
      sr_r      <= {sr_r[10:0], serBit};
      prevBit_r <= serBit;
      ph_r      <= (ph_r == `ECD_PH_LAST) ? 4'h0 : ph_r + 4'h1;
    end
  end

  // =====================================================
  // Candidate clock-bit positions
  reg  [3:0]  st_r;
  reg  [11:0] cand_r;
  reg  [7:0]  frm_r;
  reg  [3:0]  lockPh_r;
  wire [11:0] candNxt;
  wire        winEnd;
  reg  [3:0]  candCnt;
  reg  [3:0]  candIdx;
  integer     i;

  // Each phase keeps a candidate only while its pattern holds
  genvar g;
  generate
    for (g = 0; g < `ECD_FRAME_BITS; g = g + 1) begin : gCand
      assign candNxt[g] = (ph_r == g) ? (cand_r[g] & patOk) : cand_r[g];
    end
  endgenerate

  assign winEnd = (ph_r == `ECD_PH_LAST) && (frm_r == ACQ_FRAMES[7:0] - 8'h01);

  // Count surviving candidates and take the position of one
  always @* begin
    candCnt = 4'h0;
    candIdx = 4'h0;
    for (i = 0; i < `ECD_FRAME_BITS; i = i + 1) begin
      if (candNxt[i]) begin
        candCnt = candCnt + 4'h1;
        candIdx = i[3:0];
      end
    end
  end

  // =====================================================
  // Acquisition state machine
  reg  [9:0] word_r;
  reg        push_r;
  wire       bufReady;
  reg        overrun_r;

  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      st_r     <= ST_OFF;
      cand_r   <= 12'hfff;
      frm_r    <= 8'h00;
      lockPh_r <= 4'h0;
      word_r   <= `ECD_WORD_RST;
      push_r   <= 1'b0;
    end else begin
      push_r <= 1'b0;
      case (st_r)
        ST_OFF: begin
          if (refLocked) st_r <= ST_IDLE;
        end
        ST_IDLE: begin
          cand_r <= 12'hfff;
          frm_r  <= 8'h00;
          if (edgeSeen) st_r <= ST_ACQ;
        end
        ST_ACQ: begin
          // Fixed window of frames bounds the lock time
          if (ph_r == `ECD_PH_LAST) frm_r <= frm_r + 8'h01;
          cand_r <= candNxt;
          if (winEnd) begin
            cand_r <= 12'hfff;
            frm_r  <= 8'h00;
            // Lock only on a single surviving position
            if (candCnt == 4'h1) begin
              st_r     <= ST_LOCK;
              lockPh_r <= candIdx;
            end
          end
        end
        ST_LOCK: begin
          if (ph_r == lockPh_r) begin
            if (patOk) begin
              word_r <= sr_r[10:1];
              push_r <= 1'b1;
            end else begin
              st_r <= ST_ACQ;
            end
          end
        end
        default: begin
          st_r <= ST_OFF;
        end
      endcase
      if (stopped || !refLocked) st_r <= ST_OFF;
    end
  end

  // =====================================================
  // Word buffer and overrun flag
  wire locked;
  assign locked = (st_r == ST_LOCK);

  ecd_word_buffer #(
    .WIDTH (`ECD_DATA_BITS)
  ) uBuf (
    .clk      (core_clk),
    .rstN     (rstN),
    .flush    (~locked),
    .inValid  (push_r),
    .inReady  (bufReady),
    .inData   (word_r),
    .outValid (parallelWordValid),
    .outReady (parallelWordReady),
    .outData  (parallelWordOut)
  );

  // Sticky overrun, cleared when lock is lost
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) overrun_r <= 1'b0;
    else if (push_r & ~bufReady) overrun_r <= 1'b1;
    else if (!locked) overrun_r <= 1'b0;
  end
  assign wordOverrun = overrun_r;

  // =====================================================
  // Recovered clock and output drive
  reg  [4:0] offWide;
  reg        lockN_r;
  reg        recClk_r;
  reg        oe_r;

  // Offset of the current bit from the word update
  always @* begin
    offWide = {1'b0, ph_r} + 5'h0c - {1'b0, lockPh_r};
    if (offWide >= 5'h0c) offWide = offWide - 5'h0c;
  end

  // Selected edge falls mid-word, away from data change
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      lockN_r  <= `ECD_LOCK_N_RST;
      recClk_r <= 1'b0;
      oe_r     <= 1'b0;
    end else begin
      lockN_r  <= ~locked;
      recClk_r <= (offWide[3:0] > `ECD_HALF_FRAME) ~^ edgeSel;
      oe_r     <= locked & outEn;
    end
  end

  assign lockN          = lockN_r;
  assign recClkOut      = recClk_r;
  assign recClkOe       = oe_r;
  assign parallelWordOe = oe_r;
endmodule

// ===== verification/ecd_serializer_model.sv
// Serializer partner model driving the deserializer's serial input
`timescale 1ns/10ps
module ecd_serializer_model (
  // Clock
  input  wire        clk,
  // Control: 0 data, 1 training, 2 broken stop bit, 3 idle
  input  wire  [1:0] mode,
  input  wire  [9:0] word,
  // Serial line and sent word note
  output logic       serialOut,
  output logic       take,
  output logic [9:0] sentWord
);
  // ====
  // Frame builder
  logic [3:0]  phase_r = 4'h0;
  logic [11:0] frame_r = 12'h000;
  // One frame per twelve bits, first bit first
  always @(posedge clk) begin
    take <= 1'b0;
    if (phase_r == 4'h0) begin
      take <= (mode < 2'h2);
      sentWord <= (mode == 2'h1) ? 10'h3e0 : word;
      case (mode)
        2'h0: frame_r <= {1'b1, word, 1'b0};
        2'h1: frame_r <= 12'hfc0;
        2'h2: frame_r <= {1'b1, word, 1'b1};
        default: frame_r <= 12'h000;
      endcase
    end else begin
      frame_r <= {frame_r[10:0], 1'b0};
    end
    phase_r <= (phase_r == 4'hb) ? 4'h0 : phase_r + 4'h1;
  end
  assign serialOut = frame_r[11];
endmodule

// ===== verification/ecd_deserializer_checker.sv
// Assertion checker for the embedded clock deserializer
`timescale 1ns/10ps
module ecd_deserializer_checker #(
  parameter ACQ_FRAMES = 8,
  parameter REF_EDGES  = 16
) (
  // Clock and reset
  input wire       core_clk,
  input wire       rst_b,
  // Link and control
  input wire       serialIn,
  input wire       localReferenceClock,
  input wire       powerDownN,
  input wire       rxOutputEnable,
  input wire       rxEdgeSelect,
  // Status and words
  input wire       lockN,
  input wire       wordOverrun,
  input wire [9:0] parallelWordOut,
  input wire       parallelWordOe,
  input wire       parallelWordValid,
  input wire       parallelWordReady,
  input wire       recClkOut,
  input wire       recClkOe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ====
  // Cycles spent with the lock indicator high
  logic [15:0] hiCnt_r;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) hiCnt_r <= 16'h0000;
    else if (!lockN) hiCnt_r <= 16'h0000;
    else if (hiCnt_r != 16'hffff) hiCnt_r <= hiCnt_r + 16'h0001;
  end
  // Multi-step conditions
  sequence s_stopped; (!powerDownN && !rxOutputEnable)[*6]; endsequence
  sequence s_held; parallelWordValid && !parallelWordReady && !lockN; endsequence
  a_reset_keeps_off: assert property (
    $rose(rst_b) |-> (lockN && !parallelWordOe && !parallelWordValid)[*3])
    else $error("outputs active after reset");
  a_lock_not_early: assert property (
    $fell(lockN) |-> hiCnt_r >= 12 * (ACQ_FRAMES - 1)) else $error("lock came too early");
  a_oe_needs_lock: assert property (
    $rose(parallelWordOe) |-> ##[0:1] !lockN) else $error("outputs driven while unlocked");
  a_loss_floats_out: assert property (
    $rose(lockN) |-> ##[0:1] (!parallelWordOe && !recClkOe)) else $error("no float on loss");
  a_clk_oe_paired: assert property (
    recClkOe == parallelWordOe) else $error("clock and word enables differ");
  a_enable_low_floats: assert property (
    (!rxOutputEnable)[*5] |-> !parallelWordOe) else $error("driven with enable low");
  a_power_down_unlocks: assert property (
    s_stopped |-> lockN) else $error("lock kept in power down");
  a_word_held: assert property (
    s_held |=> lockN || (parallelWordValid && $stable(parallelWordOut)))
    else $error("stalled word changed");
  a_overrun_clears: assert property (
    $rose(lockN) |-> ##[0:2] !wordOverrun) else $error("overrun kept while unlocked");
  a_rec_clk_period: assert property (
    $rose(recClkOut) && recClkOe |-> ##12 ($rose(recClkOut) || !recClkOe || lockN))
    else $error("recovered clock period wrong");
endmodule

// ===== verification/ecd_deserializer_bench.sv
// Self-checking bench for the embedded clock deserializer
`timescale 1ns/10ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module ecd_deserializer_bench;
  localparam ACQ = 8;
  localparam REFS = 3;
  logic       core_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       local_reference_clock = 1'b0;
  logic       powerDownN = 1'b1;
  logic       rxOutputEnable = 1'b1;
  logic       rxEdgeSelect = 1'b1;
  logic       ready = 1'b0;
  logic       stall = 1'b0;
  logic       fixWord = 1'b0;
  logic       aligned = 1'b0;
  logic [1:0] mode = 2'h3;
  logic [9:0] txWord = 10'h000;
  logic [9:0] expWord;
  logic       serialIn, take, lockN, wordOverrun, valid, oe, recClk, recClkOe;
  logic [9:0] wordOut, sentWord;
  logic [9:0] notes[$];
  int         fail_count = 0;
  int         total_checks = 0;
  // ====
  // Clocks
  always #2.5 core_clk = ~core_clk;
  always #30 local_reference_clock = ~local_reference_clock;
  ecd_deserializer #(.ACQ_FRAMES(ACQ), .REF_EDGES(REFS)) u_ecd_deserializer (
    .core_clk(core_clk), .rst_b(rst_b), .serialIn(serialIn), .localReferenceClock(local_reference_clock),
    .powerDownN(powerDownN), .rxOutputEnable(rxOutputEnable), .rxEdgeSelect(rxEdgeSelect),
    .lockN(lockN), .wordOverrun(wordOverrun), .parallelWordOut(wordOut),
    .parallelWordOe(oe), .parallelWordValid(valid), .parallelWordReady(ready),
    .recClkOut(recClk), .recClkOe(recClkOe));
  ecd_serializer_model u_ecd_serializer_model (
    .clk(core_clk), .mode(mode), .word(txWord), .serialOut(serialIn), .take(take),
    .sentWord(sentWord));
  // Note each sent word, pick the next one and the receiver's readiness
  always @(negedge core_clk) begin
    if (take) begin
      notes.push_back(sentWord);
      if (!fixWord) txWord = 10'($urandom);
    end
    ready = stall ? 1'b0 : 1'($urandom);
  end
  // Compare each taken word with the oldest note
  always @(posedge core_clk) begin
    if (lockN !== 1'b0) aligned = 1'b0;
    else if (valid === 1'b1) begin
      // First word after lock pairs with the note before the newest one
      while (!aligned && notes.size() > 2) void'(notes.pop_front());
      aligned = 1'b1;
      if (ready) begin
        expWord = (notes.size() > 0) ? notes.pop_front() : 10'hxxx;
        `CHK(wordOut, expWord)
      end
    end
  end
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic waitLock(input int lim);
    int n;
    n = 0;
    while (lockN !== 1'b0 && n < lim) begin
      @(negedge core_clk);
      n++;
    end
  endtask
  task automatic report_and_stop();
    if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog
  initial begin
    #100000;
    fail_count++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    void'($urandom(32'hef70));
    idle(6);
    rst_b = 1'b1;
    `CHK(lockN, 1'b1)
    `CHK(oe, 1'b0)
    idle(200);
    `CHK(lockN, 1'b1)
    txWord = 10'h01f;
    fixWord = 1'b1;
    mode = 2'h0;
    idle(60);
    // Restart acquisition inside the repetitive pattern
    powerDownN = 1'b0;
    rxOutputEnable = 1'b0;
    idle(12);
    powerDownN = 1'b1;
    rxOutputEnable = 1'b1;
    idle(300);
    `CHK(lockN, 1'b1)
    mode = 2'h1;
    waitLock(4 * 12 * ACQ);
    `CHK(lockN, 1'b0)
    idle(4);
    `CHK(oe, 1'b1)
    fixWord = 1'b0;
    mode = 2'h0;
    idle(800);
    rxOutputEnable = 1'b0;
    idle(6);
    `CHK(recClkOe, 1'b0)
    `CHK(lockN, 1'b0)
    rxOutputEnable = 1'b1;
    stall = 1'b1;
    idle(72);
    `CHK(wordOverrun, 1'b1)
    mode = 2'h2;
    idle(36);
    `CHK(lockN, 1'b1)
    `CHK(oe, 1'b0)
    `CHK(wordOverrun, 1'b0)
    stall = 1'b0;
    mode = 2'h0;
    waitLock(2000);
    `CHK(lockN, 1'b0)
    powerDownN = 1'b0;
    rxOutputEnable = 1'b0;
    rxEdgeSelect = 1'b0;
    idle(12);
    `CHK(lockN, 1'b1)
    powerDownN = 1'b1;
    rxOutputEnable = 1'b1;
    waitLock(2000);
    `CHK(lockN, 1'b0)
    idle(600);
    report_and_stop();
  end
endmodule
bind ecd_deserializer ecd_deserializer_checker #(
  .ACQ_FRAMES(ACQ_FRAMES), .REF_EDGES(REF_EDGES)) u_checker (
  .core_clk(core_clk), .rst_b(rst_b), .serialIn(serialIn),
  .localReferenceClock(localReferenceClock), .powerDownN(powerDownN),
  .rxOutputEnable(rxOutputEnable), .rxEdgeSelect(rxEdgeSelect), .lockN(lockN),
  .wordOverrun(wordOverrun), .parallelWordOut(parallelWordOut),
  .parallelWordOe(parallelWordOe), .parallelWordValid(parallelWordValid),
  .parallelWordReady(parallelWordReady), .recClkOut(recClkOut), .recClkOe(recClkOe));
